/* File: design/tgw_cfg.svh */
`ifndef TGW_CFG_SVH
`define TGW_CFG_SVH

// Key register addresses on the SFR bus
`define TGW_ADDR_SINGLE_KEY     8'hC7
`define TGW_ADDR_WINDOW_KEY     8'hC9

// Registers guarded by the single-use key
`define TGW_ADDR_WATCHDOG_CTRL  8'hD8
`define TGW_ADDR_XRAM_RELOC     8'hC6
`define TGW_ADDR_ADDRESS_CTRL   8'h9D

// SFRs guarded by the windowed key
`define TGW_ADDR_CLOCK_SELECT   8'h8F
`define TGW_ADDR_WAKEUP_MASK    8'h9F

// Extended registers guarded by the windowed key
`define TGW_XADDR_REG_TRIM      16'hA000
`define TGW_XADDR_OSC_I_TRIM    16'hA001
`define TGW_XADDR_OSC_V_TRIM    16'hA002
`define TGW_XADDR_XTAL_CFG      16'hA007
`define TGW_XADDR_LVD_CFG       16'hA010
`define TGW_XADDR_LVD_THRESH    16'hA011
`define TGW_XADDR_CNT_PROT_LO   16'hA025
`define TGW_XADDR_CNT_PROT_HI   16'hA026
`define TGW_XADDR_INT_PROT_ONE  16'hA013
`define TGW_XADDR_INT_PROT_TWO  16'hA014
`define TGW_XADDR_BKPT_IRQ_EN   16'hA0E1
`define TGW_XADDR_DEBUG_ID      16'hA0EF
`define TGW_XFR_COUNT           12

// Unlock sequence and close values
`define TGW_KEY_FIRST           8'hAA
`define TGW_KEY_SECOND          8'h55
`define TGW_KEY_CLOSE           8'h00

// Status field and reset values
`define TGW_STATUS_BIT          0
`define TGW_RST_RDATA           8'h00
`define TGW_RST_WINDOW_KEY      8'h00

// Window length in system clock periods, and in cycles
`define TGW_WINDOW_PERIODS      256
`define TGW_WINDOW_CYCLES       (`TGW_WINDOW_PERIODS * 1)
`define TGW_EXTEND_PERIODS      256
`define TGW_EXTEND_CYCLES       (`TGW_EXTEND_PERIODS * 1)

`endif

/* File: design/tgw_pkg.sv */
package tgw_pkg;

    // Progress through a two-byte unlock sequence
    typedef enum logic [0:0] {
        TGW_SEQ_IDLE,
        TGW_SEQ_GOT_FIRST
    } tgw_seq_t;

endpackage

/* File: design/tgw_timer_if.sv */
`timescale 1ns/10ps

// Link between the key logic and the window timer
interface tgw_timer_if #(
    parameter int CW = 9
);
    logic          start;
    logic          close;
    logic          open;
    logic [CW-1:0] remain;

    modport ctrl  (output start, output close, input  open, input  remain);
    modport timer (input  start, input  close, output open, output remain);
endinterface

/* File: design/tgw_window_timer.sv */
`timescale 1ns/10ps
`include "tgw_cfg.svh"

module tgw_window_timer #(
    parameter int CW            = 9,
    parameter int WINDOW_CYCLES = `TGW_WINDOW_CYCLES,
    parameter int EXTEND_CYCLES = `TGW_EXTEND_CYCLES
) (
    input wire logic     clk_sys,
    input wire logic     nrst,
    tgw_timer_if.timer   tif
);

    localparam logic [CW-1:0] LOAD_OPEN   = CW'(WINDOW_CYCLES);
    localparam logic [CW-1:0] LOAD_EXTEND = CW'(EXTEND_CYCLES);
    localparam logic [CW-1:0] ONE         = CW'(1);

    logic [CW-1:0] remain_ff;

    ////////////////////////////////////////////////////////////////////////
    // Window down-counter; only runs while the core clock runs
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            remain_ff <= '0;
        end else if (tif.close) begin
            remain_ff <= '0;                          // [RL11]
        end else if (tif.start) begin
            if (remain_ff != '0) begin
                remain_ff <= LOAD_EXTEND;             // [RL10]
            end else begin
                remain_ff <= LOAD_OPEN;               // [RL8]
            end
        end else if (remain_ff != '0) begin
            remain_ff <= remain_ff - ONE;             // [RL9] [RL16]
        end
    end

    // Window is open while cycles remain
    assign tif.open   = (remain_ff != '0);
    assign tif.remain = remain_ff;

endmodule

/* File: design/tgw_guard.sv */
`timescale 1ns/10ps
`include "tgw_cfg.svh"

// Notes on behaviour
// RL1: Writing 0xAA then 0x55 to the single key grants one protected write.
// RL2: First write to a single-key register uses the grant; repeat sequence for more.
// RL3: Reads of protected registers are never blocked; only writes are gated.
// RL4: Single key guards watchdog control, XRAM relocation, address control (D8, C6, 9D).
// RL5: Single-key grant never times out; only use or voiding removes it.
// RL6: Any read or write of the single key address voids a pending grant.
// RL7: Single key reads bit 0 as 1 unlocked, 0 locked; other bits zero.
// RL8: Writing 0xAA then 0x55 to the window key opens 256 clocks of writes.
// RL9: Open window allows any number of protected writes, closes on expiry.
// RL10: Repeating the sequence while open restarts the window count.
// RL11: Writing 0x00 to the window key closes the window at once.
// RL12: Window key reads bit 0 as the current open status.
// RL13: Window key guards clock select 0x8F and wake-up mask 0x9F.
// RL14: Window key also guards twelve extended registers from 0xA000 to 0xA0EF.
// RL15: Software should close the window as soon as it is done.
// RL16: Both keys run on the core clock and hold state while it stops.
// RL17: Software should void grants and close windows before idle or stop.
// RL18: Protected writes without grant or window are refused, register unchanged.
// RL19: Any unexpected key value restarts the sequence, needing 0xAA first.
module tgw_guard #(
    parameter int WINDOW_CYCLES = `TGW_WINDOW_CYCLES,
    parameter int EXTEND_CYCLES = `TGW_EXTEND_CYCLES,
    parameter int CW            = 9
) (
    input  wire logic          CLK_SYS,
    input  wire logic          NRST,
    input  wire logic [7:0]    SFR_ADDR,
    input  wire logic          SFR_WR,
    input  wire logic          SFR_RD,
    input  wire logic [7:0]    SFR_WDATA,
    input  wire logic [15:0]   XFR_ADDR,
    input  wire logic          XFR_WR,
    output logic               SFR_WR_GRANT,
    output logic               XFR_WR_GRANT,
    output logic [7:0]         SFR_RDATA,
    output logic               SFR_RVALID,
    output logic               SINGLE_KEY_UNLOCKED,
    output logic               WINDOW_KEY_OPEN,
    output logic               WR_REFUSED,
    output logic [CW-1:0]      WINDOW_REMAIN
);

    ////////////////////////////////////////////////////////////////////////
    // Protected extended register list

    localparam logic [15:0] XFR_LIST [`TGW_XFR_COUNT] = '{
        `TGW_XADDR_REG_TRIM,
        `TGW_XADDR_OSC_I_TRIM,
        `TGW_XADDR_OSC_V_TRIM,
        `TGW_XADDR_XTAL_CFG,
        `TGW_XADDR_LVD_CFG,
        `TGW_XADDR_LVD_THRESH,
        `TGW_XADDR_CNT_PROT_LO,
        `TGW_XADDR_CNT_PROT_HI,
        `TGW_XADDR_INT_PROT_ONE,
        `TGW_XADDR_INT_PROT_TWO,
        `TGW_XADDR_BKPT_IRQ_EN,
        `TGW_XADDR_DEBUG_ID
    };

    ////////////////////////////////////////////////////////////////////////
    // Declarations

    tgw_pkg::tgw_seq_t          single_seq_ff;
    tgw_pkg::tgw_seq_t          window_seq_ff;
    logic                       unlocked_ff;
    logic [7:0]                 rdata_ff;
    logic                       rvalid_ff;
    logic                       refused_ff;

    logic                       single_key_sel;
    logic                       window_key_sel;
    logic                       single_key_op;
    logic                       single_key_wr;
    logic                       window_key_wr;
    logic                       single_prot_hit;
    logic                       window_sfr_hit;
    logic [`TGW_XFR_COUNT-1:0]  xfr_hit_vec;
    logic                       window_xfr_hit;
    logic                       ticket_used;
    logic                       sfr_refused;
    logic                       xfr_refused;
    logic                       wr_first;
    logic                       wr_second;
    logic                       wr_close;

    tgw_timer_if #(.CW(CW)) tif ();

    ////////////////////////////////////////////////////////////////////////
    // Address decode

    // Key register selects
    assign single_key_sel = (SFR_ADDR == `TGW_ADDR_SINGLE_KEY);
    assign window_key_sel = (SFR_ADDR == `TGW_ADDR_WINDOW_KEY);
    assign single_key_op  = single_key_sel && (SFR_WR || SFR_RD);
    assign single_key_wr  = single_key_sel && SFR_WR;
    assign window_key_wr  = window_key_sel && SFR_WR;

    // Registers behind the single-use key
    assign single_prot_hit = (SFR_ADDR == `TGW_ADDR_WATCHDOG_CTRL)
                          || (SFR_ADDR == `TGW_ADDR_XRAM_RELOC)
                          || (SFR_ADDR == `TGW_ADDR_ADDRESS_CTRL);   // [RL4]

    // SFRs behind the window key
    assign window_sfr_hit = (SFR_ADDR == `TGW_ADDR_CLOCK_SELECT)
                         || (SFR_ADDR == `TGW_ADDR_WAKEUP_MASK);     // [RL13]

    // One comparator per protected extended register
    genvar gi;
    generate
        for (gi = 0; gi < `TGW_XFR_COUNT; gi++) begin : g_xfr
            assign xfr_hit_vec[gi] = (XFR_ADDR == XFR_LIST[gi]);     // [RL14]
        end
    endgenerate
    assign window_xfr_hit = |xfr_hit_vec;

    // Sequence byte classes
    assign wr_first  = (SFR_WDATA == `TGW_KEY_FIRST);
    assign wr_second = (SFR_WDATA == `TGW_KEY_SECOND);
    assign wr_close  = (SFR_WDATA == `TGW_KEY_CLOSE);

    ////////////////////////////////////////////////////////////////////////
    // Write gating toward the register file

    // Grant consumed by the first single-key protected write
    assign ticket_used = SFR_WR && single_prot_hit && unlocked_ff;  // [RL2]

    // Refused protected writes
    assign sfr_refused = SFR_WR && ((single_prot_hit && !unlocked_ff)
                                 || (window_sfr_hit && !tif.open));   // [RL18]
    assign xfr_refused = XFR_WR && window_xfr_hit && !tif.open;       // [RL18]

    // Write strobes pass unless refused; reads are never touched
    assign SFR_WR_GRANT = SFR_WR && !sfr_refused;                     // [RL3] [RL9]
    assign XFR_WR_GRANT = XFR_WR && !xfr_refused;                     // [RL3] [RL9]

    ////////////////////////////////////////////////////////////////////////
    // Single-use key: sequence and ticket

    always_ff @(posedge CLK_SYS or negedge NRST) begin
        if (!NRST) begin
            single_seq_ff <= tgw_pkg::TGW_SEQ_IDLE;
        end else if (single_key_wr) begin
            if (wr_first) begin
                single_seq_ff <= tgw_pkg::TGW_SEQ_GOT_FIRST;          // [RL1]
            end else begin
                single_seq_ff <= tgw_pkg::TGW_SEQ_IDLE;               // [RL19]
            end
        end else if (single_key_op) begin
            single_seq_ff <= tgw_pkg::TGW_SEQ_IDLE;                   // [RL19]
        end
    end

    // Ticket; no timer touches it, so it waits for use or voiding
    always_ff @(posedge CLK_SYS or negedge NRST) begin
        if (!NRST) begin
            unlocked_ff <= 1'b0;
        end else if (single_key_op) begin
            unlocked_ff <= single_key_wr && wr_second
                        && (single_seq_ff == tgw_pkg::TGW_SEQ_GOT_FIRST); // [RL1] [RL6]
        end else if (ticket_used) begin
            unlocked_ff <= 1'b0;                                      // [RL2] [RL5]
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Window key: sequence, start and close

    always_ff @(posedge CLK_SYS or negedge NRST) begin
        if (!NRST) begin
            window_seq_ff <= tgw_pkg::TGW_SEQ_IDLE;
        end else if (window_key_wr) begin
            if (wr_first) begin
                window_seq_ff <= tgw_pkg::TGW_SEQ_GOT_FIRST;          // [RL8]
            end else begin
                window_seq_ff <= tgw_pkg::TGW_SEQ_IDLE;               // [RL19]
            end
        end
    end

    // Completed sequence starts or restarts the window
    assign tif.start = window_key_wr && wr_second
                    && (window_seq_ff == tgw_pkg::TGW_SEQ_GOT_FIRST); // [RL8] [RL10]
    // Zero write closes it immediately
    assign tif.close = window_key_wr && wr_close;                     // [RL11]

    // Window counter on the core clock
    tgw_window_timer #(
        .CW            (CW),
        .WINDOW_CYCLES (WINDOW_CYCLES),
        .EXTEND_CYCLES (EXTEND_CYCLES)
    ) u_timer (
        .clk_sys (CLK_SYS),
        .nrst    (NRST),
        .tif     (tif)
    );                                                                // [RL16]

    ////////////////////////////////////////////////////////////////////////
    // Key register read-back

    always_ff @(posedge CLK_SYS or negedge NRST) begin
        if (!NRST) begin
            rdata_ff  <= `TGW_RST_RDATA;
            rvalid_ff <= 1'b0;
        end else if (SFR_RD && single_key_sel) begin
            rdata_ff                  <= `TGW_RST_RDATA;
            rdata_ff[`TGW_STATUS_BIT] <= unlocked_ff;                 // [RL7]
            rvalid_ff                 <= 1'b1;
        end else if (SFR_RD && window_key_sel) begin
            rdata_ff                  <= `TGW_RST_WINDOW_KEY;
            rdata_ff[`TGW_STATUS_BIT] <= tif.open;                    // [RL12]
            rvalid_ff                 <= 1'b1;
        end else begin
            rvalid_ff <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Refused-write report

    always_ff @(posedge CLK_SYS or negedge NRST) begin
        if (!NRST) begin
            refused_ff <= 1'b0;
        end else begin
            refused_ff <= sfr_refused || xfr_refused;                 // [RL18]
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs

    assign SFR_RDATA           = rdata_ff;
    assign SFR_RVALID          = rvalid_ff;
    assign SINGLE_KEY_UNLOCKED = unlocked_ff;
    assign WINDOW_KEY_OPEN     = tif.open;
    assign WR_REFUSED          = refused_ff;
    assign WINDOW_REMAIN       = tif.remain;

endmodule

/* File: tb/tgw_guard_props.sv */
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////
module tgw_guard_props #(
    parameter int WINDOW_CYCLES = 256,
    parameter int EXTEND_CYCLES = 256,
    parameter int CW            = 9
) (
    input wire logic          CLK_SYS,
    input wire logic          NRST,
    input wire logic [7:0]    SFR_ADDR,
    input wire logic          SFR_WR,
    input wire logic          SFR_RD,
    input wire logic [7:0]    SFR_WDATA,
    input wire logic [15:0]   XFR_ADDR,
    input wire logic          XFR_WR,
    input wire logic          SFR_WR_GRANT,
    input wire logic          XFR_WR_GRANT,
    input wire logic [7:0]    SFR_RDATA,
    input wire logic          SFR_RVALID,
    input wire logic          SINGLE_KEY_UNLOCKED,
    input wire logic          WINDOW_KEY_OPEN,
    input wire logic          WR_REFUSED,
    input wire logic [CW-1:0] WINDOW_REMAIN
);
    logic key_a;
    logic kwr_b;
    logic prot_a;
    logic prot_b;
    logic prot_x;
    // Decode of the current access
    assign key_a  = (SFR_WR || SFR_RD) && SFR_ADDR == 8'hC7;
    assign kwr_b  = SFR_WR && SFR_ADDR == 8'hC9;
    assign prot_a = SFR_WR && SFR_ADDR inside {8'hD8, 8'hC6, 8'h9D};
    assign prot_b = SFR_WR && SFR_ADDR inside {8'h8F, 8'h9F};
    assign prot_x = XFR_WR && XFR_ADDR inside {16'hA000, 16'hA001, 16'hA002, 16'hA007,
        16'hA010, 16'hA011, 16'hA025, 16'hA026, 16'hA013, 16'hA014, 16'hA0E1, 16'hA0EF};
    default clocking cb @(posedge CLK_SYS);
    endclocking
    default disable iff (!NRST);
    a_single_gate: assert property (prot_a |-> SFR_WR_GRANT == SINGLE_KEY_UNLOCKED)
        else $error("single key gate wrong");
    a_ticket_used: assert property (
        prot_a && SINGLE_KEY_UNLOCKED |=> !SINGLE_KEY_UNLOCKED)
        else $error("grant not used up");
    a_no_timeout: assert property (
        SINGLE_KEY_UNLOCKED && !prot_a && !key_a |=> SINGLE_KEY_UNLOCKED)
        else $error("grant lost on its own");
    a_key_void: assert property (
        key_a && !(SFR_WR && SFR_WDATA == 8'h55) |=> !SINGLE_KEY_UNLOCKED)
        else $error("grant not voided");
    a_window_gate: assert property (prot_b |-> SFR_WR_GRANT == WINDOW_KEY_OPEN)
        else $error("window sfr gate wrong");
    a_xfr_gate: assert property (prot_x |-> XFR_WR_GRANT == WINDOW_KEY_OPEN)
        else $error("window xfr gate wrong");
    a_window_load: assert property (
        $rose(WINDOW_KEY_OPEN) |-> WINDOW_REMAIN == CW'(WINDOW_CYCLES))
        else $error("window length wrong");
    a_window_count: assert property (
        WINDOW_KEY_OPEN && !kwr_b |=> WINDOW_REMAIN == $past(WINDOW_REMAIN) - 1'b1)
        else $error("window count wrong");
    a_window_close: assert property (kwr_b && SFR_WDATA == 8'h00 |=> !WINDOW_KEY_OPEN)
        else $error("window not closed");
    a_single_status: assert property (
        SFR_RD && SFR_ADDR == 8'hC7
        |=> SFR_RVALID && SFR_RDATA == {7'h00, $past(SINGLE_KEY_UNLOCKED)})
        else $error("single status read wrong");
    a_window_status: assert property (
        SFR_RD && SFR_ADDR == 8'hC9
        |=> SFR_RVALID && SFR_RDATA == {7'h00, $past(WINDOW_KEY_OPEN)})
        else $error("window status read wrong");
    a_refused_flag: assert property ((prot_a || prot_b) && !SFR_WR_GRANT |=> WR_REFUSED)
        else $error("refusal not flagged");
    // Main scenarios reached
    c_ticket: cover property (prot_a && SFR_WR_GRANT);
    c_expiry: cover property ($fell(WINDOW_KEY_OPEN));
    c_xfr_open: cover property (prot_x && XFR_WR_GRANT);
endmodule
bind tgw_guard tgw_guard_props #(
    .WINDOW_CYCLES(WINDOW_CYCLES), .EXTEND_CYCLES(EXTEND_CYCLES), .CW(CW)
) u_props (.CLK_SYS, .NRST, .SFR_ADDR, .SFR_WR, .SFR_RD, .SFR_WDATA, .XFR_ADDR, .XFR_WR,
    .SFR_WR_GRANT, .XFR_WR_GRANT, .SFR_RDATA, .SFR_RVALID, .SINGLE_KEY_UNLOCKED,
    .WINDOW_KEY_OPEN, .WR_REFUSED, .WINDOW_REMAIN);

/* File: tb/testbench.sv */
`timescale 1ns/10ps
module testbench;
    logic        clk_sys;
    logic        nrst;
    logic [7:0]  sfr_addr;
    logic [7:0]  sfr_wdata;
    logic        sfr_wr;
    logic        sfr_rd;
    logic [15:0] xfr_addr;
    logic        xfr_wr;
    logic        sgr;
    logic        xgr;
    logic [7:0]  rdata;
    logic        rvalid;
    logic        unl;
    logic        opn;
    logic        refd;
    logic [8:0]  remain;
    int          errors;
    int          compares;
    int          n;
    logic        g;
    logic [8:0]  q;
    logic [7:0]  sa [3] = '{8'hD8, 8'hC6, 8'h9D};
    logic [15:0] xa [12] = '{16'hA000, 16'hA001, 16'hA002, 16'hA007, 16'hA010, 16'hA011,
        16'hA025, 16'hA026, 16'hA013, 16'hA014, 16'hA0E1, 16'hA0EF};
////////////////////////////////////////////////////////////////////////
    tgw_guard #(.WINDOW_CYCLES(40), .EXTEND_CYCLES(40), .CW(9)) uut (
        .CLK_SYS(clk_sys), .NRST(nrst), .SFR_ADDR(sfr_addr), .SFR_WR(sfr_wr),
        .SFR_RD(sfr_rd), .SFR_WDATA(sfr_wdata), .XFR_ADDR(xfr_addr), .XFR_WR(xfr_wr),
        .SFR_WR_GRANT(sgr), .XFR_WR_GRANT(xgr), .SFR_RDATA(rdata), .SFR_RVALID(rvalid),
        .SINGLE_KEY_UNLOCKED(unl), .WINDOW_KEY_OPEN(opn), .WR_REFUSED(refd),
        .WINDOW_REMAIN(remain));
    // Core clock, 25 ns period
    always #12.5 clk_sys = ~clk_sys;
////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic gr);
        @(negedge clk_sys);
        sfr_addr = a;
        sfr_wdata = d;
        sfr_wr = 1'b1;
        #1 gr = sgr;
        @(negedge clk_sys);
        sfr_wr = 1'b0;
    endtask
    task automatic xw(input logic [15:0] a, output logic gr);
        @(negedge clk_sys);
        xfr_addr = a;
        xfr_wr = 1'b1;
        #1 gr = xgr;
        @(negedge clk_sys);
        xfr_wr = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [8:0] r);
        @(negedge clk_sys);
        sfr_addr = a;
        sfr_rd = 1'b1;
        @(negedge clk_sys);
        r = {rvalid, rdata};
        sfr_rd = 1'b0;
    endtask
    task automatic unlock(input logic [7:0] key);
        wr(key, 8'hAA, g);
        wr(key, 8'h55, g);
    endtask
    task automatic wait_close(output int cnt);
        cnt = 0;
        while (opn === 1'b1 && cnt < 100) begin
            @(negedge clk_sys);
            cnt++;
        end
    endtask
    task automatic tally_and_finish;
        $display("errors=%0d compares=%0d", errors, compares);
        if (errors == 0 && compares > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
////////////////////////////////////////////////////////////////////////
    // Hang guard
    initial begin
        #(25 * 3000);
        errors++;
        tally_and_finish();
    end
    // Test sequence
    initial begin
        clk_sys = 1'b0;
        nrst = 1'b0;
        sfr_addr = 8'h00;
        sfr_wdata = 8'h00;
        sfr_wr = 1'b0;
        sfr_rd = 1'b0;
        xfr_addr = 16'h0000;
        xfr_wr = 1'b0;
        repeat (12) @(negedge clk_sys);
        nrst = 1'b1;
        rd(8'hC7, q);
        chk(q, 9'h100);
        rd(8'hC9, q);
        chk(q, 9'h100);
        foreach (sa[i]) begin
            wr(sa[i], 8'h5A, g);
            chk(g, 1'b0);
            chk(refd, 1'b1);
            unlock(8'hC7);
            rd(sa[i], q);
            repeat (20) @(negedge clk_sys);
            chk(unl, 1'b1);
            wr(sa[i], 8'h01, g);
            chk(g, 1'b1);
            wr(sa[i], 8'h02, g);
            chk(g, 1'b0);
        end
        unlock(8'hC7);
        rd(8'hC7, q);
        chk(q, 9'h101);
        chk(unl, 1'b0);
        unlock(8'hC7);
        wr(8'hC7, 8'h00, g);
        chk(unl, 1'b0);
        wr(8'hC7, 8'hAA, g);
        wr(8'hC7, 8'h12, g);
        wr(8'hC7, 8'h55, g);
        chk(unl, 1'b0);
        wr(8'hC7, 8'hAA, g);
        unlock(8'hC7);
        wr(8'h80, 8'h33, g);
        chk(g, 1'b1);
        wr(8'hD8, 8'h04, g);
        chk(g, 1'b1);
        wr(8'h8F, 8'h01, g);
        chk(g, 1'b0);
        unlock(8'hC9);
        rd(8'hC9, q);
        chk(q, 9'h101);
        wr(8'h8F, 8'h01, g);
        chk(g, 1'b1);
        wr(8'h9F, 8'h02, g);
        chk(g, 1'b1);
        foreach (xa[i]) begin
            xw(xa[i], g);
            chk(g, 1'b1);
        end
        wait_close(n);
        xw(16'hA0EF, g);
        chk(g, 1'b0);
        xw(16'hA003, g);
        chk(g, 1'b1);
        unlock(8'hC9);
        chk(remain, 16'h0028);
        wait_close(n);
        chk(16'(n), 16'h0028);
        unlock(8'hC9);
        repeat (10) @(negedge clk_sys);
        unlock(8'hC9);
        wait_close(n);
        chk(16'(n), 16'h0028);
        unlock(8'hC9);
        wr(8'hC9, 8'h00, g);
        chk(opn, 1'b0);
        chk(remain, 16'h0000);
        wr(8'h9F, 8'h03, g);
        chk(g, 1'b0);
        // Leave no grant pending before the core clock would stop
        unlock(8'hC7);
        chk(unl, 1'b1);
        wr(8'hC7, 8'h00, g);
        chk(unl, 1'b0);
        rd(8'hC7, q);
        chk(q, 9'h100);
        tally_and_finish();
    end
endmodule
